// ===== qot_regs.svh
`ifndef QOT_REGS_SVH
`define QOT_REGS_SVH

// ----------------------------------------------------------------
// bus geometry and register offsets
// ----------------------------------------------------------------
`define QOT_ADDR_W       8
`define QOT_OFF_CTRL     8'h00
`define QOT_OFF_START    8'h04
`define QOT_OFF_TIMER    8'h08
`define QOT_OFF_STATUS   8'h0c
`define QOT_OFF_MASK     8'h10

// ----------------------------------------------------------------
// reset values and responses
// ----------------------------------------------------------------
`define QOT_CTRL_RST     9'h000
`define QOT_TIMER_RST    16'h0000
`define QOT_RESP_OKAY    2'b00
`define QOT_RESP_SLVERR  2'b10

// ----------------------------------------------------------------
// counter limits and prescaler taps
// ----------------------------------------------------------------
`define QOT_CNT_MAX      16'hffff
`define QOT_CNT_MIN      16'h0000
`define QOT_CNT_ONE      16'h0001
`define QOT_DIV8_MASK    5'h07
`define QOT_DIV32_MASK   5'h1f

// ----------------------------------------------------------------
// channel numbers for two-phase processing choice
// ----------------------------------------------------------------
`define QOT_CH_NORM      2
`define QOT_CH_SEL       3
`define QOT_CH_X4        4

`endif

// ===== qot_pkg.sv
package qot_pkg;
`include "qot_regs.svh"

  typedef enum logic [1:0] {QOT_TRIG_FALL, QOT_TRIG_RISE, QOT_TRIG_NEIGH, QOT_TRIG_SOFT} qot_trig_e;
  typedef enum logic [1:0] {QOT_CS_F1, QOT_CS_F8, QOT_CS_F32, QOT_CS_SUB} qot_csel_e;

  // control register layout, msb first
  typedef struct packed {
    logic      nsel;
    qot_trig_e trig;
    qot_csel_e csel;
    logic      pulse_en;
    logic      x4_sel;
    logic      oneshot;
    logic      run;
  } qot_ctrl_s;

  typedef struct packed {
    logic [`QOT_ADDR_W-1:0] awaddr;
    logic                   awvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   wvalid;
    logic                   bready;
    logic [`QOT_ADDR_W-1:0] araddr;
    logic                   arvalid;
    logic                   rready;
  } qot_axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } qot_axil_rsp_s;

endpackage

// ===== qot_timer.sv
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "qot_regs.svh"
// Operation
// - two-phase mode counts each decoded valid edge once run is set
// - free-run underflow wraps without reload and sets the request bit
// - free-run overflow wraps without reload and sets the request bit
// - normal: input rising with output pin high counts up
// - normal: input falling with output pin high counts down
// - times four: four up pairings, opposite pairings count down
// - processing choice only on channel three; two normal, four times four
// - software start flag with run set starts count, output goes high
// - at zero: output low, reload, stop, request bit set
// - retrigger during count reloads on next count source tick
// - run cleared in one-shot: stop, reload, output low, request set
// - one-shot counts one of four prescaled sources, output optional
// - start by input falling, input rising, neighbour overflow or software
// - neighbour is previous or next channel, wrapping around five
// - rising trigger with run set starts count, output goes high
// - read at wrap point shows all ones or all zeros
// - output lags external trigger at most one count source cycle; the code lags the decoded trigger up to one count source cycle plus one clock
module qot_timer #(
  parameter int CHAN = `QOT_CH_SEL
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // register bus
  input  wire qot_pkg::qot_axil_req_s axil_req,
  output qot_pkg::qot_axil_rsp_s      axil_rsp,
  // pins
  input  wire logic                   timer_input_pin,
  input  wire logic                   timer_output_pin_i,
  output logic                        timer_output_pin_o,
  output logic                        timer_output_pin_oe,
  input  wire logic                   subclock_div32_source,
  // neighbour channels
  input  wire logic                   previous_channel_overflow,
  input  wire logic                   next_channel_overflow,
  output logic                        channel_overflow,
  // interrupt
  output logic                        irq
);
  import qot_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]             in_sync;
    logic                   in_filt;
    logic                   in_prev;
    logic [2:0]             out_sync;
    logic                   out_filt;
    logic                   out_prev;
    logic [2:0]             sub_sync;
    logic                   sub_filt;
    logic                   sub_prev;
    logic [4:0]             div;
    qot_ctrl_s              ctrl;
    logic                   run_prev;
    logic [15:0]            reload;
    logic [15:0]            count;
    logic                   active;
    logic                   pend;
    logic                   pin_out;
    logic                   ovf;
    logic                   status;
    logic                   mask;
    logic                   aw_got;
    logic [`QOT_ADDR_W-1:0] aw_addr;
    logic                   w_got;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
  } qot_state_s;

  qot_state_s st;
  qot_state_s next_st;

  logic in_rise, in_fall, out_rise, out_fall;
  logic up, dn, x4_mode, tick, trig, do_write, sw_start, run_fall;
  logic [31:0] rd_word;
  logic        rd_hit;

  // ----------------------------------------------------------------
  // decoded pin edges and count source
  // ----------------------------------------------------------------
  assign in_rise  = st.in_filt & ~st.in_prev;
  assign in_fall  = ~st.in_filt & st.in_prev;
  assign out_rise = st.out_filt & ~st.out_prev;
  assign out_fall = ~st.out_filt & st.out_prev;

  assign x4_mode = (CHAN == `QOT_CH_X4) || ((CHAN == `QOT_CH_SEL) && st.ctrl.x4_sel);

  always_comb begin
    if (x4_mode) begin
      up = (in_rise & st.out_filt) | (in_fall & ~st.out_filt) |
           (out_rise & ~st.in_filt) | (out_fall & st.in_filt);
      dn = (in_fall & st.out_filt) | (in_rise & ~st.out_filt) |
           (out_rise & st.in_filt) | (out_fall & ~st.in_filt);
    end else begin
      up = in_rise & st.out_filt;
      dn = in_fall & st.out_filt;
    end
  end

  always_comb begin
    case (st.ctrl.csel)
      QOT_CS_F1:  tick = 1'b1;
      QOT_CS_F8:  tick = (st.div & `QOT_DIV8_MASK) == `QOT_DIV8_MASK;
      QOT_CS_F32: tick = (st.div & `QOT_DIV32_MASK) == `QOT_DIV32_MASK;
      QOT_CS_SUB: tick = st.sub_filt & ~st.sub_prev;
      default:    tick = 1'b0;
    endcase
  end

  assign do_write = st.aw_got & st.w_got & ~st.bvalid;
  assign sw_start = do_write && (st.aw_addr == `QOT_OFF_START) && st.wstrb[0] && st.wdata[0];
  assign run_fall = st.run_prev & ~st.ctrl.run & st.ctrl.oneshot;

  always_comb begin
    case (st.ctrl.trig)
      QOT_TRIG_FALL:  trig = in_fall;
      QOT_TRIG_RISE:  trig = in_rise;
      QOT_TRIG_NEIGH: trig = st.ctrl.nsel ? next_channel_overflow : previous_channel_overflow;
      QOT_TRIG_SOFT:  trig = sw_start;
      default:        trig = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    case (axil_req.araddr)
      `QOT_OFF_CTRL:   rd_word = {23'h000000, st.ctrl};
      `QOT_OFF_START:  rd_word = 32'h0000_0000;
      `QOT_OFF_TIMER:  rd_word = {16'h0000, st.count};
      `QOT_OFF_STATUS: rd_word = {31'h0000_0000, st.status};
      `QOT_OFF_MASK:   rd_word = {31'h0000_0000, st.mask};
      default:         rd_hit  = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    // pin synchronisers, level accepted when second and third agree
    next_st.in_sync  = {st.in_sync[1:0], timer_input_pin};
    next_st.out_sync = {st.out_sync[1:0], timer_output_pin_i};
    next_st.sub_sync = {st.sub_sync[1:0], subclock_div32_source};
    if (st.in_sync[1] == st.in_sync[2]) next_st.in_filt = st.in_sync[2];
    if (st.out_sync[1] == st.out_sync[2]) next_st.out_filt = st.out_sync[2];
    if (st.sub_sync[1] == st.sub_sync[2]) next_st.sub_filt = st.sub_sync[2];
    next_st.in_prev  = st.in_filt;
    next_st.out_prev = st.out_filt;
    next_st.sub_prev = st.sub_filt;
    next_st.div      = st.div + 5'h01;
    next_st.run_prev = st.ctrl.run;
    next_st.ovf      = 1'b0;

    // bus write side
    if (axil_req.awvalid && !st.aw_got && !st.bvalid) begin
      next_st.aw_got  = 1'b1;
      next_st.aw_addr = axil_req.awaddr;
    end
    if (axil_req.wvalid && !st.w_got && !st.bvalid) begin
      next_st.w_got = 1'b1;
      next_st.wdata = axil_req.wdata;
      next_st.wstrb = axil_req.wstrb;
    end
    if (do_write) begin
      next_st.aw_got = 1'b0;
      next_st.w_got  = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp  = `QOT_RESP_OKAY;
      case (st.aw_addr)
        `QOT_OFF_CTRL: begin
          if (st.wstrb[0]) next_st.ctrl[7:0] = st.wdata[7:0];
          if (st.wstrb[1]) next_st.ctrl[8] = st.wdata[8];
        end
        `QOT_OFF_START: ;
        `QOT_OFF_TIMER: begin
          if (st.wstrb[0]) next_st.reload[7:0] = st.wdata[7:0];
          if (st.wstrb[1]) next_st.reload[15:8] = st.wdata[15:8];
          if (!st.ctrl.run) begin
            if (st.wstrb[0]) next_st.count[7:0] = st.wdata[7:0];
            if (st.wstrb[1]) next_st.count[15:8] = st.wdata[15:8];
          end
        end
        `QOT_OFF_STATUS: if (st.wstrb[0] && st.wdata[0]) next_st.status = 1'b0;
        `QOT_OFF_MASK:   if (st.wstrb[0]) next_st.mask = st.wdata[0];
        default:         next_st.bresp = `QOT_RESP_SLVERR;
      endcase
    end
    if (st.bvalid && axil_req.bready) next_st.bvalid = 1'b0;

    // bus read side
    if (axil_req.arvalid && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word;
      next_st.rresp  = rd_hit ? `QOT_RESP_OKAY : `QOT_RESP_SLVERR;
    end else if (st.rvalid && axil_req.rready) begin
      next_st.rvalid = 1'b0;
    end

    // timer core; hardware set of status wins over the clear above
    if (!st.ctrl.oneshot) begin
      next_st.active  = 1'b0;
      next_st.pend    = 1'b0;
      next_st.pin_out = 1'b0;
      if (st.ctrl.run && up && !dn) begin
        next_st.count = st.count + `QOT_CNT_ONE;
        if (st.count == `QOT_CNT_MAX) begin
          next_st.status = 1'b1;
          next_st.ovf    = 1'b1;
        end
      end else if (st.ctrl.run && dn && !up) begin
        next_st.count = st.count - `QOT_CNT_ONE;
        if (st.count == `QOT_CNT_MIN) begin
          next_st.status = 1'b1;
          next_st.ovf    = 1'b1;
        end
      end
    end else if (run_fall) begin
      next_st.active  = 1'b0;
      next_st.pend    = 1'b0;
      next_st.pin_out = 1'b0;
      next_st.count   = st.reload;
      next_st.status  = 1'b1;
    end else if (st.ctrl.run) begin
      if (trig) next_st.pend = 1'b1;
      if (tick) begin
        if (st.pend) begin
          next_st.pend    = trig;
          next_st.active  = 1'b1;
          next_st.pin_out = 1'b1;
          next_st.count   = st.reload;
        end else if (st.active) begin
          if (st.count <= `QOT_CNT_ONE) begin
            next_st.active  = 1'b0;
            next_st.pin_out = 1'b0;
            next_st.count   = st.reload;
            next_st.status  = 1'b1;
            next_st.ovf     = 1'b1;
          end else begin
            next_st.count = st.count - `QOT_CNT_ONE;
          end
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st          <= '0;
      st.ctrl     <= `QOT_CTRL_RST;
      st.reload   <= `QOT_TIMER_RST;
      st.count    <= `QOT_TIMER_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign axil_rsp.awready    = ~st.aw_got & ~st.bvalid;
  assign axil_rsp.wready     = ~st.w_got & ~st.bvalid;
  assign axil_rsp.bvalid     = st.bvalid;
  assign axil_rsp.bresp      = st.bresp;
  assign axil_rsp.arready    = ~st.rvalid;
  assign axil_rsp.rvalid     = st.rvalid;
  assign axil_rsp.rdata      = st.rdata;
  assign axil_rsp.rresp      = st.rresp;
  assign timer_output_pin_o  = st.pin_out;
  assign timer_output_pin_oe = st.ctrl.oneshot & st.ctrl.pulse_en;
  assign channel_overflow    = st.ovf;
  assign irq                 = st.status & st.mask;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic os_run;
  assign os_run = st.ctrl.oneshot & st.ctrl.run & ~run_fall;

  sequence s_started;
    st.pin_out && st.active && (st.count == $past(st.reload));
  endsequence

  sequence s_finished;
    !st.pin_out && !st.active && st.status && (st.count == $past(st.reload));
  endsequence

  a_overflow_wrap: assert property (
    (!st.ctrl.oneshot && st.ctrl.run && up && !dn && st.count == `QOT_CNT_MAX)
    |=> (st.count == `QOT_CNT_MIN) && st.status && channel_overflow)
    else $error("overflow did not wrap to zero with request");

  a_underflow_wrap: assert property (
    (!st.ctrl.oneshot && st.ctrl.run && dn && !up && st.count == `QOT_CNT_MIN)
    |=> (st.count == `QOT_CNT_MAX) && st.status && channel_overflow)
    else $error("underflow did not wrap to all ones with request");

  a_normal_up: assert property (
    (!st.ctrl.oneshot && st.ctrl.run && !x4_mode && in_rise && st.out_filt)
    |=> st.count == $past(st.count) + `QOT_CNT_ONE)
    else $error("normal up count missed");

  a_normal_down: assert property (
    (!st.ctrl.oneshot && st.ctrl.run && !x4_mode && in_fall && st.out_filt)
    |=> st.count == $past(st.count) - `QOT_CNT_ONE)
    else $error("normal down count missed");

  a_x4_out_fall: assert property (
    (!st.ctrl.oneshot && st.ctrl.run && x4_mode && out_fall && st.in_filt && !in_rise && !in_fall)
    |=> st.count == $past(st.count) + `QOT_CNT_ONE)
    else $error("times four up count on output fall missed");

  a_os_start: assert property (
    (os_run && tick && st.pend) |=> s_started)
    else $error("one-shot did not start on tick");

  a_os_finish: assert property (
    (os_run && tick && !st.pend && st.active && st.count <= `QOT_CNT_ONE) |=> s_finished)
    else $error("one-shot did not end at zero");

  a_run_clear: assert property (
    run_fall |=> !timer_output_pin_o && st.status && !st.active ##1 !st.active)
    else $error("run clear did not stop one-shot");

  a_trigger_lag: assert property (
    (os_run && st.ctrl.csel == QOT_CS_F1 && trig && !st.active && !st.pend)
    |=> ##1 st.pin_out)
    else $error("one-shot output lagged trigger too long");

  a_hold_stopped: assert property (
    (!st.ctrl.run && !st.run_prev && !do_write) |=> $stable(st.count))
    else $error("counter moved while run clear");

  a_x4_in_rise: assert property (
    (!st.ctrl.oneshot && st.ctrl.run && x4_mode && in_rise && !st.out_filt && !out_rise && !out_fall)
    |=> st.count == $past(st.count) - `QOT_CNT_ONE)
    else $error("times four down count on input rise missed");

  a_soft_start: assert property (
    (os_run && st.ctrl.trig == QOT_TRIG_SOFT && sw_start) |=> st.pend)
    else $error("software start flag was not taken");

  a_retrig_pend: assert property (
    (os_run && st.active && trig) |=> st.pend)
    else $error("retrigger during count was lost");

  a_neigh_pick: assert property (
    (os_run && st.ctrl.trig == QOT_TRIG_NEIGH && (st.ctrl.nsel ? next_channel_overflow : previous_channel_overflow))
    |=> st.pend)
    else $error("selected neighbour overflow did not trigger");

  a_stopped_quiet: assert property (
    (st.ctrl.oneshot && !st.ctrl.run && !st.run_prev) |=> !st.pin_out && !st.pend)
    else $error("one-shot moved while run clear");

endmodule

// ===== qot_encoder.sv
`timescale 1ns/10ps
// ----------------------------------------
// two-phase encoder and trigger source
// ----------------------------------------
module qot_encoder #(
  parameter int HOLD = 8
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // step commands
  input  wire logic fwd,
  input  wire logic back,
  input  wire logic slow,
  // phases
  output logic      in_pin,
  output logic      out_pin,
  output logic      busy
);
  logic [1:0] ph;
  int         hold;

  // phase order as (in,out): 01, 11, 10, 00
  assign in_pin  = ph[0] ^ ph[1];
  assign out_pin = !ph[1];
  assign busy    = hold != 0;

  // each level is held long enough for the pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ph   <= 2'h0;
      hold <= 0;
    end else if (hold != 0) begin
      hold <= hold - 1;
    end else if (fwd || back) begin
      ph   <= fwd ? ph + 2'h1 : ph - 2'h1;
      hold <= slow ? 4 * HOLD : HOLD;
    end
  end
endmodule

// ===== quadrature_and_oneshot_timer_bench.sv
`timescale 1ns/10ps
`include "qot_regs.svh"
module quadrature_and_oneshot_timer_bench;
  import qot_pkg::*;
  localparam logic [1:0] OK  = `QOT_RESP_OKAY;
  localparam logic [1:0] ERR = `QOT_RESP_SLVERR;
  logic          aclk = 1'b0;
  logic          aresetn = 1'b0;
  qot_axil_req_s req = '0;
  qot_axil_rsp_s rsp;
  logic          fwd = 1'b0;
  logic          back = 1'b0;
  logic          slow = 1'b0;
  logic          prev_ov = 1'b0;
  logic          next_ov = 1'b0;
  logic          sub = 1'b0;
  logic          in_pin, out_pin, busy, pin_o, oe, ov, irq;
  int            n_fail = 0;
  int            checked = 0;
  int            hi_cnt = 0;
  int            ov_cnt = 0;
  int            sub_div = 0;

  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    sub_div <= (sub_div == 15) ? 0 : sub_div + 1;
    if (sub_div == 15) sub <= ~sub;
  end
  always @(posedge aclk) if (pin_o === 1'b1) hi_cnt <= hi_cnt + 1;
  always @(posedge aclk) if (ov === 1'b1) ov_cnt <= ov_cnt + 1;

  qot_timer u_qot_timer (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
    .timer_input_pin(in_pin), .timer_output_pin_i(out_pin), .timer_output_pin_o(pin_o),
    .timer_output_pin_oe(oe), .subclock_div32_source(sub), .previous_channel_overflow(prev_ov),
    .next_channel_overflow(next_ov), .channel_overflow(ov), .irq(irq));
  qot_encoder u_qot_encoder (.aclk(aclk), .aresetn(aresetn), .fwd(fwd), .back(back), .slow(slow),
    .in_pin(in_pin), .out_pin(out_pin), .busy(busy));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tally_and_finish;
    if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic timeout;
    n_fail++;
    $display("mismatch at %0t: wait timed out", $time);
    tally_and_finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw;
    bit w;
    aw = 0;
    w = 0;
    req.awaddr  <= a;
    req.wdata   <= d;
    req.wstrb   <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (!aw && rsp.awready) begin
        aw = 1;
        req.awvalid <= 1'b0;
      end
      if (!w && rsp.wready) begin
        w = 1;
        req.wvalid <= 1'b0;
      end
      if (rsp.bvalid) begin
        cmp(rsp.bresp, er);
        return;
      end
    end
    timeout;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    bit ar;
    ar = 0;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (!ar && rsp.arready) begin
        ar = 1;
        req.arvalid <= 1'b0;
      end
      if (rsp.rvalid) begin
        cmp(rsp.rdata, exp);
        cmp(rsp.rresp, er);
        return;
      end
    end
    timeout;
  endtask

  task automatic step(input bit up);
    fwd  <= up;
    back <= !up;
    @(posedge aclk);
    fwd  <= 1'b0;
    back <= 1'b0;
    for (int n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (busy === 1'b0) return;
    end
    timeout;
  endtask

  task automatic pulse(input bit p);
    prev_ov <= p;
    next_ov <= !p;
    @(posedge aclk);
    prev_ov <= 1'b0;
    next_ov <= 1'b0;
  endtask

  function automatic logic [31:0] oc(input logic [1:0] t, input logic [1:0] cs, input logic ns);
    return {23'h0, ns, t, cs, 4'hb};
  endfunction

  // how: 0 encoder rise then fall, 1 previous, 2 next, 3 software
  task automatic shot(input logic [31:0] c, input int how, input int rl, input int expw);
    int w0;
    wr(`QOT_OFF_TIMER, rl, OK);
    wr(`QOT_OFF_CTRL, c, OK);
    w0 = hi_cnt;
    if (how == 0) begin
      step(1);
      step(0);
    end else if (how == 3) begin
      wr(`QOT_OFF_START, 32'h1, OK);
    end else begin
      pulse(how == 2);
      repeat (8) @(posedge aclk);
      cmp(hi_cnt - w0, 0);
      pulse(how == 1);
    end
    for (int n = 0; n < 500 && irq !== 1'b1; n++) @(posedge aclk);
    if (irq !== 1'b1) timeout;
    repeat (2) @(posedge aclk);
    cmp(hi_cnt - w0, expw);
    rd(`QOT_OFF_TIMER, rl, OK);
    wr(`QOT_OFF_STATUS, 32'h1, OK);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(`QOT_OFF_CTRL, 0, OK);
    rd(`QOT_OFF_TIMER, 0, OK);
    rd(`QOT_OFF_STATUS, 0, OK);
    rd(8'h20, 0, ERR);
    wr(8'h20, 32'h1, ERR);
    cmp(irq, 0);
    cmp(oe, 0);
  endtask

  task automatic t_quad;
    slow <= 1'b1;
    wr(`QOT_OFF_MASK, 32'h1, OK);
    wr(`QOT_OFF_TIMER, 32'h5, OK);
    repeat (4) step(1);
    rd(`QOT_OFF_TIMER, 32'h5, OK);
    wr(`QOT_OFF_CTRL, 32'h1, OK);
    repeat (4) step(1);
    rd(`QOT_OFF_TIMER, 32'h6, OK);
    repeat (4) step(0);
    rd(`QOT_OFF_TIMER, 32'h5, OK);
    slow <= 1'b0;
    wr(`QOT_OFF_CTRL, 32'h5, OK);
    repeat (3) step(1);
    rd(`QOT_OFF_TIMER, 32'h8, OK);
    repeat (2) step(0);
    rd(`QOT_OFF_TIMER, 32'h6, OK);
    wr(`QOT_OFF_CTRL, 32'h0, OK);
    wr(`QOT_OFF_TIMER, 32'h0, OK);
    wr(`QOT_OFF_CTRL, 32'h5, OK);
    step(0);
    rd(`QOT_OFF_TIMER, 32'hffff, OK);
    cmp(irq, 1);
    wr(`QOT_OFF_STATUS, 32'h1, OK);
    cmp(irq, 0);
    step(1);
    rd(`QOT_OFF_TIMER, 32'h0, OK);
    cmp(irq, 1);
    wr(`QOT_OFF_STATUS, 32'h1, OK);
    wr(`QOT_OFF_CTRL, 32'h0, OK);
    step(0);
    cmp(ov_cnt, 2);
  endtask

  task automatic t_trig;
    for (int t = 0; t < 4; t++) shot(oc(t, 0, 0), (t < 2) ? 0 : ((t == 2) ? 1 : 3), 3, 3);
    shot(oc(2, 0, 1), 2, 3, 3);
  endtask

  task automatic t_csel;
    int dv[4] = '{1, 8, 32, 32};
    for (int s = 0; s < 4; s++) shot(oc(3, s, 0), 3, 3, 3 * dv[s]);
    cmp(oe, 1);
    wr(`QOT_OFF_CTRL, oc(3, 0, 0) & 32'h1f7, OK);
    cmp(oe, 0);
  endtask

  task automatic t_retrig;
    int w;
    wr(`QOT_OFF_TIMER, 32'ha, OK);
    wr(`QOT_OFF_CTRL, oc(3, 0, 0), OK);
    w = hi_cnt;
    wr(`QOT_OFF_START, 32'h1, OK);
    wr(`QOT_OFF_START, 32'h1, OK);
    for (int n = 0; n < 500 && irq !== 1'b1; n++) @(posedge aclk);
    if (irq !== 1'b1) timeout;
    w = hi_cnt - w;
    cmp(w > 10 && w < 17, 1);
    wr(`QOT_OFF_STATUS, 32'h1, OK);
  endtask

  task automatic t_stop;
    int w;
    wr(`QOT_OFF_TIMER, 32'h64, OK);
    wr(`QOT_OFF_START, 32'h1, OK);
    repeat (6) @(posedge aclk);
    cmp(pin_o, 1);
    wr(`QOT_OFF_CTRL, oc(3, 0, 0) & 32'h1fe, OK);
    repeat (2) @(posedge aclk);
    cmp(pin_o, 0);
    cmp(irq, 1);
    rd(`QOT_OFF_TIMER, 32'h64, OK);
    wr(`QOT_OFF_STATUS, 32'h1, OK);
    w = hi_cnt;
    wr(`QOT_OFF_START, 32'h1, OK);
    repeat (10) @(posedge aclk);
    cmp(hi_cnt - w, 0);
  endtask

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_quad();
    t_trig();
    t_csel();
    t_retrig();
    t_stop();
    tally_and_finish();
  end
endmodule
